// >>> rtl/touch_ctrl_device.sv
// Overview of operation
// RULE_01: settle, other, scan position writable only setup
// RULE_02: host waits long ack times per mode
// RULE_03: command 01 stores config, 120 ms blocked
// RULE_04: 02 factory restore, 03 writes defaults; 120ms
// RULE_05: command 04 loads stored defaults, 5 ms
// RULE_06: 05 reloads ram, 06 setup-only reconfig; 5ms
// RULE_07: 07 normal, 08 setup, 00 revision, immediate
// RULE_08: 09 scan start 10ms, 0a stop 5ms
// RULE_09: command is address, offset a0, code byte
// RULE_10: pin status register mirrors real output levels
// RULE_11: second-sensor registers absent on one-button part
// RULE_12: stall link after each byte until processed
// RULE_13: setup acks slower unless scanning stopped
// RULE_14: read-only and locked writes leave contents
`timescale 1ns/100ps
`include "touch_ctrl_defs.svh"

module touch_ctrl_device #(
  parameter int          TWO_BUTTON   = 1,
  parameter logic [7:0]  PART_ID      = 8'h5a,  // arbitrary value
  parameter logic [7:0]  FW_REVISION  = 8'h10,
  parameter int          ACK_NORM_CYC = `ACK_NORMAL_CYC,
  parameter int          ACK_SETUP_CYC= `ACK_SETUP_CYC,
  parameter int          LONG_CYC     = `MS_TO_CYC(`BLOCK_LONG_MS),
  parameter int          MID_CYC      = `MS_TO_CYC(`BLOCK_MID_MS),
  parameter int          SHORT_CYC    = `MS_TO_CYC(`BLOCK_SHORT_MS)
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // link
  touch_link_if.device_end link,
  // core side
  input  wire logic [1:0]  pin_level_i,
  input  wire logic [15:0] baseline_i,
  input  wire logic [15:0] difference_i,
  input  wire logic [15:0] raw_i,
  input  wire logic [7:0]  touch_state_i,
  output logic             setup_mode_o,
  output logic             scanning_o,
  output logic [7:0]       nvm_cmd_o,
  output logic             nvm_cmd_valid_o
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cfg_r [0:255];
  logic [7:0] ptr_r;
  logic       have_ptr_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_level_bits_r;
  logic [31:0] cnt_r;
  logic [7:0] rd_data_nxt;
  logic [7:0] last_rev_r;
  touch_ctrl_pkg::dev_state_t st_r;
  logic       pend_rd_r;
  logic       pend_nak_r;

  function automatic logic setup_only(input logic [7:0] a);
    setup_only = (a == `REG_SETTLE_TIME) || (a == `REG_OTHER_SET) ||
                 (a == `REG_SCAN_POS0) || (a == `REG_SCAN_POS1);
  endfunction

  function automatic logic is_rw(input logic [7:0] a);
    logic second;
    second = (a == `REG_SCAN_POS1) || (a == `REG_THRESH1) || (a == `REG_CURRENT1);
    is_rw  = (((a >= `REG_SETTLE_TIME) && (a <= `REG_FILTER)) ||
              (a == `REG_SCAN_POS0) || (a == `REG_SCAN_POS1) ||
              (a == `REG_THRESH0) || (a == `REG_THRESH1) ||
              (a == `REG_CURRENT0) || (a == `REG_CURRENT1) ||
              (a == `REG_ADDR_LOCK) || (a == `REG_ADDR_DRIVE) ||
              (a == `REG_READ_SEL)) && !(second && (TWO_BUTTON == 0)); // see RULE_11
  endfunction

  function automatic logic [31:0] block_len(input logic [7:0] c);
    case (c)
      touch_ctrl_pkg::CMD_STORE_NVM,
      touch_ctrl_pkg::CMD_FACTORY,
      touch_ctrl_pkg::CMD_WRITE_POR:  block_len = 32'(LONG_CYC);   // see RULE_03 see RULE_04
      touch_ctrl_pkg::CMD_READ_POR,
      touch_ctrl_pkg::CMD_RELOAD_RAM,
      touch_ctrl_pkg::CMD_RECONFIG,
      touch_ctrl_pkg::CMD_SCAN_STOP:  block_len = 32'(SHORT_CYC);  // see RULE_05 see RULE_06
      touch_ctrl_pkg::CMD_SCAN_START: block_len = 32'(MID_CYC);    // see RULE_08
      default:                        block_len = 32'h0;           // see RULE_07
    endcase
  endfunction

  // ----------------------------------------
  // pin level sampling
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r         <= 2'h3;
      pin_level_bits_r <= 2'h3;
    end else begin
      pin_s1_r         <= pin_level_i;
      pin_level_bits_r <= (TWO_BUTTON != 0) ? pin_s1_r : {1'b0, pin_s1_r[0]}; // see RULE_10
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_data_nxt = 8'h00;
    case (ptr_r)
      `REG_PIN_STATUS:  rd_data_nxt = {6'h00, pin_level_bits_r}; // see RULE_10
      `REG_PART_ID:     rd_data_nxt = PART_ID;
      `REG_DEV_STATE:   rd_data_nxt = {5'h00, setup_mode_o, scanning_o, 1'b1};
      `REG_BASE_HI:     rd_data_nxt = baseline_i[15:8];
      `REG_BASE_LO:     rd_data_nxt = baseline_i[7:0];
      `REG_DIFF_HI:     rd_data_nxt = difference_i[15:8];
      `REG_DIFF_LO:     rd_data_nxt = difference_i[7:0];
      `REG_RAW_HI:      rd_data_nxt = raw_i[15:8];
      `REG_RAW_LO:      rd_data_nxt = raw_i[7:0];
      `REG_TOUCH_STATE: rd_data_nxt = touch_state_i;
      `REG_COMMAND:     rd_data_nxt = last_rev_r;
      default:          rd_data_nxt = is_rw(ptr_r) ? cfg_r[ptr_r] : 8'h00;
    endcase
  end

  // ----------------------------------------
  // byte processing with stall
  // ----------------------------------------
  logic [7:0] wbyte_r;
  logic       wr_go;
  logic       cmd_go;
  assign wr_go  = (st_r == touch_ctrl_pkg::DS_STALL) && (cnt_r == 32'h0) && !pend_rd_r &&
                  have_ptr_r && (ptr_r != `REG_COMMAND);
  assign cmd_go = (st_r == touch_ctrl_pkg::DS_STALL) && (cnt_r == 32'h0) && !pend_rd_r &&
                  have_ptr_r && (ptr_r == `REG_COMMAND);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r        <= touch_ctrl_pkg::DS_IDLE;
      cnt_r       <= 32'h0;
      ptr_r       <= 8'h00;
      have_ptr_r  <= 1'b0;
      pend_rd_r   <= 1'b0;
      pend_nak_r  <= 1'b0;
      wbyte_r     <= 8'h00;
      link.stall  <= 1'b0;
      link.ack    <= 1'b0;
      link.nak    <= 1'b0;
      link.byte_r <= 8'h00;
    end else begin
      link.ack <= 1'b0;
      link.nak <= 1'b0;
      if (link.start) have_ptr_r <= 1'b0;
      case (st_r)
        touch_ctrl_pkg::DS_IDLE: begin
          if (link.byte_valid) begin
            st_r       <= touch_ctrl_pkg::DS_STALL;
            link.stall <= 1'b1;                               // see RULE_12
            pend_rd_r  <= link.rd;
            wbyte_r    <= link.byte_w;
            // setup acks slow while scanning; fast once stopped
            cnt_r      <= (setup_mode_o && scanning_o) ? 32'(ACK_SETUP_CYC - 1)
                                                       : 32'(ACK_NORM_CYC - 1); // see RULE_13
          end
        end
        touch_ctrl_pkg::DS_STALL: begin
          if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
          end else begin
            link.stall <= 1'b0;
            link.ack   <= 1'b1;
            st_r       <= touch_ctrl_pkg::DS_IDLE;
            if (pend_rd_r) begin
              link.byte_r <= rd_data_nxt;
              ptr_r       <= ptr_r + 8'h01;
            end else if (!have_ptr_r) begin
              ptr_r      <= wbyte_r;
              have_ptr_r <= 1'b1;
            end else if (cmd_go) begin
              if (block_len(wbyte_r) != 32'h0) begin
                st_r  <= touch_ctrl_pkg::DS_BLOCK;
                cnt_r <= block_len(wbyte_r);
              end
            end else begin
              ptr_r <= ptr_r + 8'h01;
            end
          end
        end
        touch_ctrl_pkg::DS_BLOCK: begin
          // link bytes offered here are simply not acknowledged
          if (cnt_r > 32'h1) cnt_r <= cnt_r - 32'h1;
          else st_r <= touch_ctrl_pkg::DS_IDLE;
        end
        default: st_r <= touch_ctrl_pkg::DS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // configuration store
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 256; i++) cfg_r[i] <= 8'h00;
      cfg_r[`REG_SETTLE_TIME] <= `RST_SETTLE_TIME;
      cfg_r[`REG_OTHER_SET]   <= `RST_OTHER_SET;
      cfg_r[`REG_HYSTERESIS]  <= `RST_HYSTERESIS;
      cfg_r[`REG_DEBOUNCE]    <= `RST_DEBOUNCE;
      cfg_r[`REG_NEG_NOISE]   <= `RST_NEG_NOISE;
      cfg_r[`REG_LOW_BL_RST]  <= `RST_LOW_BL_RST;
      cfg_r[`REG_FILTER]      <= `RST_FILTER;
      cfg_r[`REG_SCAN_POS0]   <= `RST_SCAN_POS0;
      cfg_r[`REG_SCAN_POS1]   <= `RST_SCAN_POS1;
      cfg_r[`REG_THRESH0]     <= `RST_THRESH;
      cfg_r[`REG_THRESH1]     <= `RST_THRESH;
      cfg_r[`REG_CURRENT0]    <= `RST_CURRENT;
      cfg_r[`REG_CURRENT1]    <= `RST_CURRENT;
      cfg_r[`REG_ADDR_LOCK]   <= `RST_ADDR_LOCK;
      cfg_r[`REG_ADDR_DRIVE]  <= `RST_ADDR_DRIVE;
      cfg_r[`REG_READ_SEL]    <= `RST_READ_SEL;
    end else if (wr_go && is_rw(ptr_r) &&
                 (setup_mode_o || !setup_only(ptr_r))) begin     // see RULE_01 see RULE_14
      cfg_r[ptr_r] <= wbyte_r;
    end
  end

  // ----------------------------------------
  // command execution
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_mode_o    <= 1'b0;
      scanning_o      <= 1'b1;
      nvm_cmd_o       <= 8'h00;
      nvm_cmd_valid_o <= 1'b0;
      last_rev_r      <= 8'h00;
    end else begin
      nvm_cmd_valid_o <= 1'b0;
      if (cmd_go) begin
        case (wbyte_r)
          touch_ctrl_pkg::CMD_GET_REV:    last_rev_r   <= FW_REVISION;   // see RULE_07
          touch_ctrl_pkg::CMD_NORMAL:     setup_mode_o <= 1'b0;          // see RULE_07
          touch_ctrl_pkg::CMD_SETUP:      setup_mode_o <= 1'b1;          // see RULE_07
          touch_ctrl_pkg::CMD_SCAN_START: scanning_o   <= 1'b1;          // see RULE_08
          touch_ctrl_pkg::CMD_SCAN_STOP:  scanning_o   <= 1'b0;          // see RULE_08
          touch_ctrl_pkg::CMD_SCAN_STAT:  last_rev_r   <= {7'h00, scanning_o};
          touch_ctrl_pkg::CMD_STORE_NVM,
          touch_ctrl_pkg::CMD_FACTORY,
          touch_ctrl_pkg::CMD_WRITE_POR,
          touch_ctrl_pkg::CMD_READ_POR,
          touch_ctrl_pkg::CMD_RELOAD_RAM: begin                          // see RULE_03 see RULE_05
            nvm_cmd_o       <= wbyte_r;
            nvm_cmd_valid_o <= 1'b1;
          end
          touch_ctrl_pkg::CMD_RECONFIG: begin
            if (setup_mode_o) begin                                      // see RULE_06
              nvm_cmd_o       <= wbyte_r;
              nvm_cmd_valid_o <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule // touch_ctrl_device

// >>> rtl/touch_ctrl_defs.svh
`ifndef TOUCH_CTRL_DEFS_SVH
`define TOUCH_CTRL_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_PIN_STATUS      8'h00
`define REG_SETTLE_TIME     8'h50
`define REG_OTHER_SET       8'h51
`define REG_HYSTERESIS      8'h52
`define REG_DEBOUNCE        8'h53
`define REG_NEG_NOISE       8'h54
`define REG_LOW_BL_RST      8'h55
`define REG_FILTER          8'h56
`define REG_SCAN_POS0       8'h5c
`define REG_SCAN_POS1       8'h5d
`define REG_THRESH0         8'h66
`define REG_THRESH1         8'h67
`define REG_CURRENT0        8'h70
`define REG_CURRENT1        8'h71
`define REG_ADDR_LOCK       8'h79
`define REG_PART_ID         8'h7a
`define REG_DEV_STATE       8'h7b
`define REG_ADDR_DRIVE      8'h7c
`define REG_READ_SEL        8'h81
`define REG_BASE_HI         8'h82
`define REG_BASE_LO         8'h83
`define REG_DIFF_HI         8'h84
`define REG_DIFF_LO         8'h85
`define REG_RAW_HI          8'h86
`define REG_RAW_LO          8'h87
`define REG_TOUCH_STATE     8'h88
`define REG_COMMAND         8'ha0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_SETTLE_TIME     8'ha0
`define RST_OTHER_SET       8'h00
`define RST_HYSTERESIS      8'h0a
`define RST_DEBOUNCE        8'h03
`define RST_NEG_NOISE       8'h14
`define RST_LOW_BL_RST      8'h14
`define RST_FILTER          8'h20
`define RST_SCAN_POS0       8'h00
`define RST_SCAN_POS1       8'h01
`define RST_THRESH          8'h64
`define RST_CURRENT         8'h0a
`define RST_ADDR_LOCK       8'h01
`define RST_DEV_STATE       8'h03
`define RST_ADDR_DRIVE      8'h80
`define RST_READ_SEL        8'h81

// ----------------------------------------
// host-side control registers (wishbone)
// ----------------------------------------
`define HREG_CTRL           8'h00
`define HREG_ADDR           8'h04
`define HREG_WDATA          8'h08
`define HREG_RDATA          8'h0c
`define HREG_STATUS         8'h10
`define HCTRL_GO_BIT        0
`define HCTRL_READ_BIT      1
`define HSTAT_BUSY_BIT      0
`define HSTAT_ERR_BIT       1

// ----------------------------------------
// timing, 100 mhz clock
// ----------------------------------------
`define CLK_PERIOD_NS       10
`define ACK_NORMAL_NS       110000
`define ACK_SETUP_NS        11000000
`define BLOCK_LONG_MS       120
`define BLOCK_MID_MS        10
`define BLOCK_SHORT_MS      5
`define MS_TO_CYC(ms)       ((ms) * 1000000 / `CLK_PERIOD_NS)
`define ACK_NORMAL_CYC      (`ACK_NORMAL_NS / `CLK_PERIOD_NS)
`define ACK_SETUP_CYC       (`ACK_SETUP_NS / `CLK_PERIOD_NS)

`endif

// >>> rtl/touch_ctrl_pkg.sv
package touch_ctrl_pkg;

  typedef enum logic [7:0] {
    CMD_GET_REV    = 8'h00,
    CMD_STORE_NVM  = 8'h01,
    CMD_FACTORY    = 8'h02,
    CMD_WRITE_POR  = 8'h03,
    CMD_READ_POR   = 8'h04,
    CMD_RELOAD_RAM = 8'h05,
    CMD_RECONFIG   = 8'h06,
    CMD_NORMAL     = 8'h07,
    CMD_SETUP      = 8'h08,
    CMD_SCAN_START = 8'h09,
    CMD_SCAN_STOP  = 8'h0a,
    CMD_SCAN_STAT  = 8'h0b
  } command_t;

  typedef enum logic [1:0] {
    DS_IDLE   = 2'b00,
    DS_STALL  = 2'b01,
    DS_BLOCK  = 2'b10
  } dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE    = 3'b000,
    HS_ADDR    = 3'b001,
    HS_WAIT_A  = 3'b010,
    HS_DATA    = 3'b011,
    HS_WAIT_D  = 3'b100,
    HS_DONE    = 3'b101
  } host_state_t;

endpackage

// >>> rtl/touch_link_if.sv
`timescale 1ns/100ps

// byte-level view of the serial link: host offers a byte, device
// stretches (stall) until it has processed it, then acks; the device never raises nak
interface touch_link_if;
  logic       start;
  logic       rd;
  logic [7:0] byte_w;
  logic       byte_valid;
  logic       stall;
  logic       ack;
  logic       nak;
  logic [7:0] byte_r;

  modport device_end (
    input  start,
    input  rd,
    input  byte_w,
    input  byte_valid,
    output stall,
    output ack,
    output nak,
    output byte_r
  );

  modport host_end (
    output start,
    output rd,
    output byte_w,
    output byte_valid,
    input  stall,
    input  ack,
    input  nak,
    input  byte_r
  );
endinterface

// >>> rtl/touch_ctrl_host.sv
`timescale 1ns/100ps
`include "touch_ctrl_defs.svh"

module touch_ctrl_host (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // link
  touch_link_if.host_end   link
);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic       rd_r;
  logic       err_r;
  logic       go;
  touch_ctrl_pkg::host_state_t hs_r;

  assign go = cyc_i && stb_i && !ack_o && we_i && sel_i[0] &&
              (adr_i == `HREG_CTRL) && dat_i[`HCTRL_GO_BIT] &&
              (hs_r == touch_ctrl_pkg::HS_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      dat_o   <= 32'h0;
      addr_r  <= 8'h00;
      wdata_r <= 8'h00;
      rd_r    <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= 32'h0;
      if (cyc_i && stb_i && !ack_o) begin
        if (we_i && sel_i[0]) begin
          case (adr_i)
            `HREG_ADDR:  addr_r  <= dat_i[7:0];
            `HREG_WDATA: wdata_r <= dat_i[7:0];
            `HREG_CTRL:  if (go) rd_r <= dat_i[`HCTRL_READ_BIT];
            default: ;
          endcase
        end else if (!we_i) begin
          case (adr_i)
            `HREG_ADDR:   dat_o <= {24'h0, addr_r};
            `HREG_WDATA:  dat_o <= {24'h0, wdata_r};
            `HREG_RDATA:  dat_o <= {24'h0, rdata_r};
            `HREG_STATUS: dat_o <= {30'h0, err_r, hs_r != touch_ctrl_pkg::HS_IDLE};
            default:      dat_o <= 32'h0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_r            <= touch_ctrl_pkg::HS_IDLE;
      err_r           <= 1'b0;
      rdata_r         <= 8'h00;
      link.start      <= 1'b0;
      link.rd         <= 1'b0;
      link.byte_w     <= 8'h00;
      link.byte_valid <= 1'b0;
    end else begin
      link.start      <= 1'b0;
      link.byte_valid <= 1'b0;
      case (hs_r)
        touch_ctrl_pkg::HS_IDLE: if (go) begin
          err_r      <= 1'b0;
          link.start <= 1'b1;
          hs_r       <= touch_ctrl_pkg::HS_ADDR;
        end
        touch_ctrl_pkg::HS_ADDR: begin
          link.rd         <= 1'b0;
          link.byte_w     <= addr_r;                                // see RULE_09
          link.byte_valid <= 1'b1;
          hs_r            <= touch_ctrl_pkg::HS_WAIT_A;
        end
        // waits as long as the device stretches; no fixed ack time assumed
        touch_ctrl_pkg::HS_WAIT_A: if (link.ack) begin              // see RULE_02
          hs_r <= touch_ctrl_pkg::HS_DATA;
        end
        touch_ctrl_pkg::HS_DATA: begin
          link.rd         <= rd_r;
          link.byte_w     <= wdata_r;                               // see RULE_09
          link.byte_valid <= 1'b1;
          hs_r            <= touch_ctrl_pkg::HS_WAIT_D;
        end
        touch_ctrl_pkg::HS_WAIT_D: if (link.ack || link.nak) begin
          err_r <= link.nak;
          if (rd_r) rdata_r <= link.byte_r;
          hs_r  <= touch_ctrl_pkg::HS_DONE;
        end
        // software polls busy and must not start during blocked time
        touch_ctrl_pkg::HS_DONE: hs_r <= touch_ctrl_pkg::HS_IDLE;   // see RULE_03
        default: hs_r <= touch_ctrl_pkg::HS_IDLE;
      endcase
    end
  end

endmodule // touch_ctrl_host

// >>> bench/touch_ctrl_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// link handshake checker
// ----------------------------------------
module touch_ctrl_chk #(
  parameter int ACK_NORM_CYC  = 4,
  parameter int ACK_SETUP_CYC = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // link
  input  wire logic byte_valid,
  input  wire logic stall,
  input  wire logic ack,
  input  wire logic nak,
  // device mode
  input  wire logic setup_mode_o,
  input  wire logic scanning_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [31:0] stall_cnt_r;
  logic        slow_r;

  // counter, since setup stalls are too long to unroll
  always_ff @(posedge clk_i) begin
    if (rst_i || !stall) begin
      stall_cnt_r <= '0;
    end else begin
      stall_cnt_r <= stall_cnt_r + 32'h1;
    end
  end

  // mode at the edge the byte is taken decides its wait
  always_ff @(posedge clk_i) begin
    if (byte_valid && !stall) begin
      slow_r <= setup_mode_o && scanning_o;
    end
  end

  sequence s_quick_done;
    stall [*4] ##1 (ack && !stall);
  endsequence

  a_quick_ack_time: assert property ($rose(stall) && !setup_mode_o |-> s_quick_done)
    else $error("normal mode byte not answered in time");
  a_mode_ack_time: assert property ($fell(stall) |->
      stall_cnt_r == (slow_r ? ACK_SETUP_CYC : ACK_NORM_CYC))
    else $error("stall length does not match mode");
  a_stall_has_cause: assert property ($rose(stall) |-> $past(byte_valid))
    else $error("stall without a byte");
  a_release_acks: assert property ($fell(stall) |-> ack)
    else $error("stall released without ack");
  a_ack_after_stall: assert property (ack |-> $past(stall))
    else $error("ack without a preceding stall");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_no_offer_stall: assert property (byte_valid |-> !stall)
    else $error("byte offered while stalled");
  a_nak_idle: assert property (!nak)
    else $error("nak raised");
  a_reset_state: assert property ($fell(rst_i) |->
      !stall && !ack && !setup_mode_o && scanning_o)
    else $error("device not in reset state");
endmodule // touch_ctrl_chk

// >>> bench/testbench.sv
`timescale 1ns/100ps
`include "touch_ctrl_defs.svh"

module testbench;
  localparam logic [7:0] ID_CODE = 8'h3c;  // arbitrary value
  localparam logic [7:0] REV     = 8'h27;  // arbitrary value

  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i, touch_state_i, nvm_cmd_o, nvm_code;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic [1:0]  pin_level_i;
  logic [15:0] baseline_i, difference_i, raw_i;
  logic        setup_mode_o, scanning_o, nvm_cmd_valid_o, nvm_seen;
  int          err_total, checks;

  touch_link_if link();
  touch_ctrl_host u_touch_ctrl_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .link(link));
  touch_ctrl_device #(.PART_ID(ID_CODE), .FW_REVISION(REV), .ACK_NORM_CYC(4),
    .ACK_SETUP_CYC(8), .LONG_CYC(40), .MID_CYC(20), .SHORT_CYC(10)) u_touch_ctrl_device (
    .clk_i(clk_i), .rst_i(rst_i), .link(link), .pin_level_i(pin_level_i),
    .baseline_i(baseline_i), .difference_i(difference_i), .raw_i(raw_i),
    .touch_state_i(touch_state_i), .setup_mode_o(setup_mode_o), .scanning_o(scanning_o),
    .nvm_cmd_o(nvm_cmd_o), .nvm_cmd_valid_o(nvm_cmd_valid_o));
  touch_ctrl_chk #(.ACK_NORM_CYC(4), .ACK_SETUP_CYC(8)) u_touch_ctrl_chk (.clk_i(clk_i),
    .rst_i(rst_i), .byte_valid(link.byte_valid), .stall(link.stall), .ack(link.ack),
    .nak(link.nak), .setup_mode_o(setup_mode_o), .scanning_o(scanning_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // nonvolatile request monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (nvm_cmd_valid_o === 1'b1) begin
      nvm_seen <= 1'b1;
      nvm_code <= nvm_cmd_o;
    end
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task wait_expired(input string what);
    err_total++;
    $display("unexpected %s expected done seen busy", what);
    print_verdict();
  endtask

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (n >= 50) wait_expired("bus ack");
  endtask

  // one register access across the link; polls the host until idle
  task link_access(input logic is_rd, input logic [7:0] off, input logic [7:0] wd,
                   output logic [7:0] q);
    logic [31:0] v;
    int n;
    n = 0;
    wb_cycle(1'b1, `HREG_ADDR, {24'h0, off}, v);
    wb_cycle(1'b1, `HREG_WDATA, {24'h0, wd}, v);
    wb_cycle(1'b1, `HREG_CTRL, {30'h0, is_rd, 1'b1}, v);
    do begin
      wb_cycle(1'b0, `HREG_STATUS, 32'h0, v);
      n++;
    end while (v[`HSTAT_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) wait_expired("link transfer");
    wb_cycle(1'b0, `HREG_RDATA, 32'h0, v);
    q = v[7:0];
  endtask

  task reg_wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] q;
    link_access(1'b0, off, d, q);
  endtask

  task reg_chk(input string what, input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] q;
    link_access(1'b1, off, 8'h00, q);
    cmp_byte(what, exp, q);
  endtask

  // host stays off the link for the whole blocked interval
  task command(input logic [7:0] code, input int block);
    reg_wr(8'ha0, code);
    repeat (block + 4) @(posedge clk_i);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    logic [7:0] offs [18] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h5c,
      8'h5d, 8'h66, 8'h67, 8'h70, 8'h71, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h81};
    logic [7:0] exps [18] = '{8'ha0, 8'h00, 8'h0a, 8'h03, 8'h14, 8'h14, 8'h20, 8'h00,
      8'h01, 8'h64, 8'h64, 8'h0a, 8'h0a, 8'h01, ID_CODE, 8'h03, 8'h80, 8'h81};
    for (int i = 0; i < 18; i++) reg_chk("reset value", offs[i], exps[i]);
    $display("test reset values done");
  endtask

  task t_pins;
    pin_level_i <= 2'b01;
    repeat (4) @(posedge clk_i);
    reg_chk("pin levels", 8'h00, 8'h01);
    pin_level_i <= 2'b10;
    repeat (4) @(posedge clk_i);
    reg_chk("pin levels", 8'h00, 8'h02);
    $display("test pin levels done");
  endtask

  task t_rw;
    logic [31:0] v;
    reg_wr(8'h52, 8'hff);
    reg_chk("hysteresis", 8'h52, 8'hff);
    reg_wr(8'h5d, 8'h00);
    reg_chk("second scan position", 8'h5d, 8'h01);
    reg_wr(8'h67, 8'h2a);
    reg_chk("second threshold", 8'h67, 8'h2a);
    reg_wr(8'h7a, 8'hff);
    reg_chk("identity", 8'h7a, ID_CODE);
    reg_wr(8'h00, 8'hff);
    reg_chk("pin status", 8'h00, 8'h02);
    reg_wr(8'h50, 8'h11);
    reg_chk("settle time", 8'h50, 8'ha0);
    wb_cycle(1'b0, 8'h3c, 32'h0, v);
    cmp_byte("unmapped host read", 8'h00, v[7:0]);
    $display("test access rights done");
  endtask

  task t_setup;
    command(8'h08, 0);
    cmp_bit("setup mode", 1'b1, setup_mode_o);
    reg_wr(8'h50, 8'h55);
    reg_chk("settle time", 8'h50, 8'h55);
    reg_wr(8'h51, 8'h0f);
    reg_chk("other settings", 8'h51, 8'h0f);
    reg_wr(8'h5c, 8'h01);
    reg_chk("first scan position", 8'h5c, 8'h01);
    command(8'h0a, 10);
    cmp_bit("scanning", 1'b0, scanning_o);
    reg_chk("hysteresis", 8'h52, 8'hff);
    command(8'h09, 20);
    cmp_bit("scanning", 1'b1, scanning_o);
    command(8'h07, 0);
    cmp_bit("setup mode", 1'b0, setup_mode_o);
    $display("test setup mode done");
  endtask

  task automatic t_commands;
    logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0a,
      8'h09, 8'h0b};
    int blocks [10] = '{0, 40, 40, 40, 10, 10, 10, 10, 20, 0};
    for (int i = 0; i < 10; i++) begin
      nvm_seen = 1'b0;
      command(codes[i], blocks[i]);
      if (codes[i] == 8'h00) reg_chk("revision", 8'ha0, REV);
      if (codes[i] >= 8'h01 && codes[i] <= 8'h04) begin
        cmp_bit("nvm request", 1'b1, nvm_seen);
        cmp_byte("nvm code", codes[i], nvm_code);
      end
    end
    cmp_bit("scanning", 1'b1, scanning_o);
    $display("test commands done");
  endtask

  task automatic t_readback;
    logic [7:0] exps [7] = '{8'hfe, 8'hdc, 8'h02, 8'h46, 8'h9a, 8'hbc, 8'ha5};
    baseline_i <= 16'hfedc;
    difference_i <= 16'h0246;
    touch_state_i <= 8'ha5;
    for (int i = 0; i < 7; i++) reg_chk("count readback", 8'h82 + 8'(i), exps[i]);
    $display("test readback done");
  endtask

  initial begin
    err_total = 0;
    checks = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h1;
    dat_i = 32'h0;
    pin_level_i = 2'b10;
    baseline_i = 16'h1234;
    difference_i = 16'h5678;
    raw_i = 16'h9abc;
    touch_state_i = 8'h3c;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_pins();
    t_rw();
    t_setup();
    t_commands();
    t_readback();
    print_verdict();
  end
endmodule // testbench
